// File: core/mac_reset_gate.sv
`timescale 1ns/100ps
module mac_reset_gate (
  input wire logic    sys_clk_in,
  input wire logic    rst_in,
  mac_reset_if.gate   port_if
);
  logic run_meta_q;
  logic run_sync_q;
  logic reset_q;

  // The running flag comes from the MAC clock domain, so it is synchronised first.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      run_meta_q <= 1'b0;
      run_sync_q <= 1'b0;
      reset_q    <= 1'b1;
    end else begin
      run_meta_q <= port_if.clk_running_raw;
      run_sync_q <= run_meta_q;
      if (port_if.hold) begin
        reset_q <= 1'b1;
      end else if (run_sync_q) begin
        reset_q <= 1'b0;
      end
    end
  end

  assign port_if.mac_reset = reset_q;
endmodule : mac_reset_gate

// File: core/mac_reset_if.sv
`timescale 1ns/100ps
interface mac_reset_if;
  logic clk_running_raw;
  logic hold;
  logic mac_reset;
  modport gate (input clk_running_raw, input hold, output mac_reset);
  modport ctrl (output clk_running_raw, output hold, input mac_reset);
endinterface : mac_reset_if

// File: core/power_mgmt_control_reg.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module power_mgmt_control_reg
  import power_mgmt_pkg::*;
#(
  parameter int PHY_HOLD_CNT   = PHY_HOLD_CYCLES,
  parameter int ANA_SETTLE_CNT = ANA_SETTLE_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic        phy_reset_req_in,
  input  wire logic        config_loading_in,
  input  wire logic        eee_wake_event_in,
  input  wire logic        resume_done_in,
  input  wire logic        resume_remote_in,
  input  wire logic        unconfigured_in,
  input  wire logic        suspended_in,
  input  wire logic        unpowered_in,
  input  wire logic [1:0]  mac_clk_running_in,
  output logic      [1:0]  mac_reset_out,
  output logic             phy_reset_out,
  output logic             analog_ref_on_out,
  output logic             crystal_run_out,
  output logic      [1:0]  sleep_level_out,
  output logic             eee_wake_request_out,
  output logic             clear_wake_status_out,
  output logic             clear_wake_enables_out
);
  localparam logic [SEQ_CNT_W-1:0] HOLD_LAST   = SEQ_CNT_W'(PHY_HOLD_CNT - 1);
  localparam logic [SEQ_CNT_W-1:0] SETTLE_LAST = SEQ_CNT_W'(ANA_SETTLE_CNT - 1);

  logic                 ana_ref_wait_dis_q;
  logic                 xtal_inhibit_q;
  logic                 eee_wake_en_q;
  logic                 eee_wake_en_d;
  logic                 eee_wake_sts_q;
  logic                 eee_wake_sts_d;
  logic                 mac_soft_reset_q;
  logic                 res_clr_sts_q;
  logic                 res_clr_en_q;
  logic [1:0]           sleep_lvl_q;
  logic [1:0]           sleep_lvl_d;
  logic [31:0]          rdata_q;
  phy_seq_e             seq_q;
  phy_seq_e             seq_d;
  logic [SEQ_CNT_W-1:0] seq_cnt_q;
  logic [SEQ_CNT_W-1:0] seq_cnt_d;
  logic                 ref_was_off_q;
  logic                 ready_q;
  logic                 phy_reset_q;
  logic                 analog_ref_on_q;
  logic                 crystal_run_q;
  logic [1:0]           sleep_level_q;
  logic                 eee_wake_req_q;
  logic                 clr_sts_pulse_q;
  logic                 clr_en_pulse_q;

  wire        reg_hit     = (reg_addr_in == PMC_OFFSET);
  wire        wr_hit      = reg_wr_in & reg_hit;
  wire        rd_hit      = reg_rd_in & reg_hit;
  wire        remote_done = resume_done_in & resume_remote_in;
  wire        clear_sts   = remote_done & res_clr_sts_q;
  wire        clear_en    = remote_done & res_clr_en_q;
  wire        sts_w1c     = wr_hit & reg_wdata_in[EEE_WAKE_STS_BIT];
  wire [1:0]  wr_sleep    = reg_wdata_in[SLEEP_LVL_LSB +: 2];
  wire        seq_restart = phy_reset_req_in & (seq_q == PHY_RUN);
  wire        hold_done   = (seq_q == PHY_HOLD) & (seq_cnt_q == HOLD_LAST);
  wire        settle_done = (seq_q == PHY_SETTLE) & (seq_cnt_q == SETTLE_LAST);

  // Unused and reserved positions stay zero in the read word.
  wire [31:0] read_word = {16'h0000,
                           ana_ref_wait_dis_q,
                           xtal_inhibit_q,
                           eee_wake_en_q,
                           eee_wake_sts_q,
                           mac_soft_reset_q,
                           1'b0,
                           res_clr_sts_q,
                           res_clr_en_q,
                           ready_q,
                           sleep_lvl_q,
                           5'h00};

  // Hardware sets win over software and resume clears so no wake event is lost.
  always_comb begin
    eee_wake_sts_d = eee_wake_sts_q;
    if (sts_w1c | clear_sts) begin
      eee_wake_sts_d = 1'b0;
    end
    if (eee_wake_event_in) begin
      eee_wake_sts_d = 1'b1;
    end
  end

  always_comb begin
    eee_wake_en_d = eee_wake_en_q;
    if (wr_hit) begin
      eee_wake_en_d = reg_wdata_in[EEE_WAKE_EN_BIT];
    end
    if (clear_en) begin
      eee_wake_en_d = 1'b0;
    end
  end

  // A write that also clears status still loads the suspend field from bits 6:5.
  always_comb begin
    sleep_lvl_d = sleep_lvl_q;
    if (wr_hit) begin
      sleep_lvl_d = wr_sleep;
    end
    if (unconfigured_in) begin
      sleep_lvl_d = SLEEP_LVL_RST;
    end
  end

  always_comb begin
    seq_d     = seq_q;
    seq_cnt_d = seq_cnt_q + 1'b1;
    case (seq_q)
      PHY_HOLD: begin
        if (hold_done) begin
          seq_cnt_d = '0;
          seq_d     = ref_was_off_q ? PHY_SETTLE : PHY_RUN;
        end
      end
      PHY_SETTLE: begin
        if (settle_done) begin
          seq_cnt_d = '0;
          seq_d     = PHY_RUN;
        end
      end
      PHY_RUN: begin
        seq_cnt_d = '0;
        if (seq_restart) begin
          seq_d = PHY_HOLD;
        end
      end
      default: begin
        seq_cnt_d = '0;
        seq_d     = PHY_HOLD;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ana_ref_wait_dis_q <= ANA_REF_WAIT_DIS_RST;
      xtal_inhibit_q     <= XTAL_INHIBIT_RST;
      mac_soft_reset_q         <= MAC_SOFT_RESET_RST;
      res_clr_sts_q      <= RES_CLR_STS_RST;
      res_clr_en_q       <= RES_CLR_EN_RST;
    end else if (wr_hit) begin
      ana_ref_wait_dis_q <= reg_wdata_in[ANA_REF_WAIT_DIS_BIT];
      xtal_inhibit_q     <= reg_wdata_in[XTAL_INHIBIT_BIT];
      mac_soft_reset_q         <= reg_wdata_in[MAC_SOFT_RESET_BIT];
      res_clr_sts_q      <= reg_wdata_in[RES_CLR_STS_BIT];
      res_clr_en_q       <= reg_wdata_in[RES_CLR_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      eee_wake_en_q  <= EEE_WAKE_EN_RST;
      eee_wake_sts_q <= EEE_WAKE_STS_RST;
      sleep_lvl_q    <= SLEEP_LVL_RST;
      rdata_q        <= 32'h0000_0000;
    end else begin
      eee_wake_en_q  <= eee_wake_en_d;
      eee_wake_sts_q <= eee_wake_sts_d;
      sleep_lvl_q    <= sleep_lvl_d;
      rdata_q        <= rd_hit ? read_word : 32'h0000_0000;
    end
  end

  // The reference setting is captured when a hold starts, so the settle wait
  // follows what the PHY actually went through rather than a later write.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      seq_q         <= PHY_HOLD;
      seq_cnt_q     <= '0;
      ref_was_off_q <= 1'b1;
    end else begin
      seq_q     <= seq_d;
      seq_cnt_q <= seq_cnt_d;
      if (seq_restart) begin
        ref_was_off_q <= ~ana_ref_wait_dis_q;
      end
    end
  end

  wire ready_d   = (seq_q == PHY_RUN) & ~seq_restart & ~config_loading_in;
  wire ref_on_d  = ~((seq_d == PHY_HOLD) & (seq_restart ? ~ana_ref_wait_dis_q : ref_was_off_q));
  wire deep_sleep = suspended_in & (sleep_lvl_q == SLEEP_LEVEL_TWO);
  wire xtal_d    = xtal_inhibit_q | ~(deep_sleep | unpowered_in);
  wire [1:0] lvl_d = (sleep_lvl_q == SLEEP_LEVEL_ONE) ? SLEEP_LEVEL_ZERO : sleep_lvl_q;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ready_q         <= 1'b0;
      phy_reset_q     <= 1'b1;
      analog_ref_on_q <= 1'b0;
      crystal_run_q   <= 1'b1;
      sleep_level_q   <= SLEEP_LVL_RST;
      eee_wake_req_q  <= 1'b0;
      clr_sts_pulse_q <= 1'b0;
      clr_en_pulse_q  <= 1'b0;
    end else begin
      ready_q         <= ready_d;
      phy_reset_q     <= (seq_d == PHY_HOLD);
      analog_ref_on_q <= ref_on_d;
      crystal_run_q   <= xtal_d;
      sleep_level_q   <= lvl_d;
      eee_wake_req_q  <= eee_wake_sts_q & eee_wake_en_q;
      clr_sts_pulse_q <= clear_sts;
      clr_en_pulse_q  <= clear_en;
    end
  end

  mac_reset_if mac_if [MAC_DOMAINS] ();

  genvar g;
  generate
    for (g = 0; g < MAC_DOMAINS; g++) begin : g_mac
      assign mac_if[g].clk_running_raw = mac_clk_running_in[g];
      assign mac_if[g].hold            = mac_soft_reset_q;
      mac_reset_gate u_gate (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .port_if    (mac_if[g])
      );
      assign mac_reset_out[g] = mac_if[g].mac_reset;
    end
  endgenerate

  assign reg_rdata_out          = rdata_q;
  assign phy_reset_out          = phy_reset_q;
  assign analog_ref_on_out      = analog_ref_on_q;
  assign crystal_run_out        = crystal_run_q;
  assign sleep_level_out        = sleep_level_q;
  assign eee_wake_request_out   = eee_wake_req_q;
  assign clear_wake_status_out  = clr_sts_pulse_q;
  assign clear_wake_enables_out = clr_en_pulse_q;
endmodule : power_mgmt_control_reg

// File: core/power_mgmt_pkg.sv
// Behaviour
// - Bit 15 set keeps the analog reference powered during a PHY reset.
// - A reset with the reference off waits about 100 ms for PHY settling.
// - Bit 14 set keeps the crystal running in every suspend and unpowered state.
// - Energy-efficient wake status raises a wake request only while bit 13 is set.
// - A remote resume end clears bit 13 when resume-clears-enables is set.
// - Bit 12 sets on an energy-efficient wake regardless of enable; write 1 clears.
// - A remote resume end clears bit 12 when resume-clears-status is set.
// - Bit 11 high holds MAC receive and transmit domains in reset.
// - MAC resets release only while the matching MAC clock runs.
// - Bit 9 set clears the listed wake flags at the end of a remote resume.
// - Bit 9 set also clears wake cause bit 1 and bit 12 on resume end.
// - Status clearing applies only to remote resumes; host resumes clear nothing.
// - Bit 9 clear leaves all wake status flags untouched after any resume.
// - Bit 8, reset 1, clears all wake enables after a remote resume ends.
// - Bit 7 is read-only ready, resets 0, reads 1 once the device is ready.
// - Ready stays low until the PHY reset sequence ends and PHY runs.
// - Ready also stays low while configuration content loads.
// - Bits 6:5, reset 10b, pick the suspend level entered on host suspend.
// - Becoming unconfigured reloads the suspend field with 10b.
// - Suspend codes 00 and 01 behave identically.
// - The PHY reset sequence stretches to 104 ms with the reference off.
package power_mgmt_pkg;
  localparam logic [7:0]  PMC_OFFSET         = 8'h14;
  localparam int          ANA_REF_WAIT_DIS_BIT = 15;
  localparam int          XTAL_INHIBIT_BIT   = 14;
  localparam int          EEE_WAKE_EN_BIT    = 13;
  localparam int          EEE_WAKE_STS_BIT   = 12;
  localparam int          MAC_SOFT_RESET_BIT       = 11;
  localparam int          RES_CLR_STS_BIT    = 9;
  localparam int          RES_CLR_EN_BIT     = 8;
  localparam int          READY_BIT          = 7;
  localparam int          SLEEP_LVL_LSB      = 5;
  localparam logic        ANA_REF_WAIT_DIS_RST = 1'b0;
  // Crystal inhibit reset value comes from configuration memory; a plain zero is used.
  localparam logic        XTAL_INHIBIT_RST   = 1'b0;
  localparam logic        EEE_WAKE_EN_RST    = 1'b0;
  localparam logic        EEE_WAKE_STS_RST   = 1'b0;
  localparam logic        MAC_SOFT_RESET_RST       = 1'b0;
  localparam logic        RES_CLR_STS_RST    = 1'b0;
  localparam logic        RES_CLR_EN_RST     = 1'b1;
  localparam logic [1:0]  SLEEP_LVL_RST      = 2'h2;
  localparam logic [1:0]  SLEEP_LEVEL_ZERO   = 2'h0;
  localparam logic [1:0]  SLEEP_LEVEL_ONE    = 2'h1;
  localparam logic [1:0]  SLEEP_LEVEL_TWO    = 2'h2;
  localparam logic [1:0]  SLEEP_LEVEL_THREE  = 2'h3;
  localparam int          CLK_HZ             = 50_000_000;
  localparam int          PHY_HOLD_MS        = 4;
  localparam int          ANA_SETTLE_MS      = 100;
  localparam int          PHY_HOLD_CYCLES    = PHY_HOLD_MS * (CLK_HZ / 1000);
  localparam int          ANA_SETTLE_CYCLES  = ANA_SETTLE_MS * (CLK_HZ / 1000);
  localparam int          SEQ_CNT_W          = 23;
  localparam int          MAC_DOMAINS        = 2;
  typedef enum logic [1:0] {
    PHY_HOLD   = 2'h0,
    PHY_SETTLE = 2'h1,
    PHY_RUN    = 2'h3
  } phy_seq_e;
endpackage : power_mgmt_pkg

// File: test/power_mgmt_control_reg_sva.sv
`timescale 1ns/100ps
module power_mgmt_control_reg_sva
  import power_mgmt_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        config_loading_in,
  input wire logic        resume_done_in,
  input wire logic        resume_remote_in,
  input wire logic        unconfigured_in,
  input wire logic        suspended_in,
  input wire logic        unpowered_in,
  input wire logic [1:0]  mac_clk_running_in,
  input wire logic [1:0]  mac_reset_out,
  input wire logic        phy_reset_out,
  input wire logic        crystal_run_out,
  input wire logic [1:0]  sleep_level_out,
  input wire logic        clear_wake_status_out,
  input wire logic        clear_wake_enables_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_rsvd_zero;
    reg_rd_in |=> reg_rdata_out[31:16] == 16'h0000 && !reg_rdata_out[10];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");
  property p_ready_phy;
    reg_rd_in && phy_reset_out |=> !reg_rdata_out[READY_BIT];
  endproperty
  a_ready_phy: assert property (p_ready_phy) else $error("ready high in phy reset");
  // The load level is seen one cycle late by the ready flag, so two samples are asked for.
  property p_ready_cfg;
    reg_rd_in && config_loading_in && $past(config_loading_in) |=> !reg_rdata_out[READY_BIT];
  endproperty
  a_ready_cfg: assert property (p_ready_cfg) else $error("ready high while loading");
  property p_host_res;
    !(resume_done_in && resume_remote_in) |=> !clear_wake_status_out && !clear_wake_enables_out;
  endproperty
  a_host_res: assert property (p_host_res) else $error("clear pulse without remote resume");
  property p_mac_hold;
    reg_wr_in && reg_addr_in == PMC_OFFSET && reg_wdata_in[MAC_SOFT_RESET_BIT] |-> ##[1:2] mac_reset_out == 2'h3;
  endproperty
  a_mac_hold: assert property (p_mac_hold) else $error("mac not held in reset");
  property p_mac_clk;
    ($fell(mac_reset_out[0]) |-> $past(mac_clk_running_in[0], 3)) and
    ($fell(mac_reset_out[1]) |-> $past(mac_clk_running_in[1], 3));
  endproperty
  a_mac_clk: assert property (p_mac_clk) else $error("mac reset released without clock");
  property p_xtal;
    $past(!suspended_in && !unpowered_in) |-> crystal_run_out;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal stopped while awake");
  property p_unconf;
    unconfigured_in |-> ##2 sleep_level_out == SLEEP_LEVEL_TWO;
  endproperty
  a_unconf: assert property (p_unconf) else $error("level not reloaded");
  property p_no_lvl_one;
    sleep_level_out != SLEEP_LEVEL_ONE;
  endproperty
  a_no_lvl_one: assert property (p_no_lvl_one) else $error("level one reported");
endmodule : power_mgmt_control_reg_sva

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import power_mgmt_pkg::*;
  logic        sys_clk_in, rst_in, reg_wr_in, reg_rd_in, phy_reset_req_in, config_loading_in;
  logic        eee_wake_event_in, resume_done_in, resume_remote_in, unconfigured_in;
  logic        suspended_in, unpowered_in, phy_reset_out, analog_ref_on_out, crystal_run_out;
  logic        eee_wake_request_out, clear_wake_status_out, clear_wake_enables_out;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, rv, d;
  logic [1:0]  mac_clk_running_in, mac_reset_out, sleep_level_out;
  int          n_mismatch, check_count, cyc, n;

  power_mgmt_control_reg #(.PHY_HOLD_CNT(8), .ANA_SETTLE_CNT(16)) i_power_mgmt_control_reg (.*);

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // Writable bits with the ready flag assumed high.
  function automatic logic [31:0] exp_word(input logic [31:0] w);
    return (w & 32'h0000EB60) | 32'h00000080;
  endfunction : exp_word

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge sys_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= w;
    reg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    rv = reg_rdata_out;
  endtask : rd

  task automatic pulse(input int k);
    @(posedge sys_clk_in);
    case (k)
      0: eee_wake_event_in <= 1'b1;
      1: resume_done_in <= 1'b1;
      2: unconfigured_in <= 1'b1;
      default: phy_reset_req_in <= 1'b1;
    endcase
    @(posedge sys_clk_in);
    {eee_wake_event_in, resume_done_in, unconfigured_in, phy_reset_req_in} <= 4'h0;
    @(negedge sys_clk_in);
  endtask : pulse

  task automatic wait_ready();
    n = 0;
    do begin
      rd(PMC_OFFSET);
      n++;
    end while (rv[READY_BIT] !== 1'b1 && n < 40);
  endtask : wait_ready

  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    rst_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    {reg_wr_in, reg_rd_in, phy_reset_req_in, config_loading_in} = 4'h0;
    {eee_wake_event_in, resume_done_in, resume_remote_in, unconfigured_in} = 4'h0;
    {suspended_in, unpowered_in} = 2'h0;
    mac_clk_running_in = 2'h3;
    void'($urandom(40003));
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(PMC_OFFSET);
    chk(rv, 32'h00000140);
    wait_ready();
    chk(32'(n > 8), 32'h1);
    chk(rv, 32'h000001C0);
    @(posedge sys_clk_in);
    config_loading_in <= 1'b1;
    rd(PMC_OFFSET);
    chk(32'(rv[READY_BIT]), 32'h0);
    config_loading_in <= 1'b0;
    wr(PMC_OFFSET, 32'hFFFFFFFF);
    rd(PMC_OFFSET);
    chk(rv, 32'h0000EBE0);
    repeat (16) begin
      d = $urandom & 32'hFFFFEFFF;
      wr(PMC_OFFSET, d);
      wr({1'b1, 7'($urandom)}, 32'hFFFFFFFF);
      rd(PMC_OFFSET);
      chk(rv, exp_word(d));
      rd({1'b1, 7'($urandom)});
      chk(rv, 32'h0);
    end
    for (int c = 0; c < 4; c++) begin
      wr(PMC_OFFSET, 32'(c) << 5);
      repeat (2) @(posedge sys_clk_in);
      @(negedge sys_clk_in) chk(32'(sleep_level_out), (c == 1) ? 32'h0 : 32'(c));
    end
    pulse(2);
    rd(PMC_OFFSET);
    chk(rv, 32'h000000C0);
    @(posedge sys_clk_in);
    suspended_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in) chk(32'(crystal_run_out), 32'h0);
    wr(PMC_OFFSET, 32'h00004040);
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in) chk(32'(crystal_run_out), 32'h1);
    wr(PMC_OFFSET, 32'h00002040);
    pulse(0);
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in) chk(32'(eee_wake_request_out), 32'h1);
    @(posedge sys_clk_in);
    suspended_in <= 1'b0;
    resume_remote_in <= 1'b1;
    pulse(1);
    chk(32'({clear_wake_status_out, clear_wake_enables_out}), 32'h0);
    rd(PMC_OFFSET);
    chk(rv, 32'h000030C0);
    wr(PMC_OFFSET, 32'h00001040);
    rd(PMC_OFFSET);
    chk(rv, 32'h000000C0);
    pulse(0);
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in) chk(32'(eee_wake_request_out), 32'h0);
    wr(PMC_OFFSET, 32'h00002340);
    @(posedge sys_clk_in);
    resume_remote_in <= 1'b0;
    pulse(1);
    chk(32'({clear_wake_status_out, clear_wake_enables_out}), 32'h0);
    rd(PMC_OFFSET);
    chk(rv, 32'h000033C0);
    @(posedge sys_clk_in);
    resume_remote_in <= 1'b1;
    pulse(1);
    chk(32'({clear_wake_status_out, clear_wake_enables_out}), 32'h3);
    rd(PMC_OFFSET);
    chk(rv, 32'h000003C0);
    wr(PMC_OFFSET, 32'h00000840);
    @(posedge sys_clk_in);
    @(negedge sys_clk_in) chk(32'(mac_reset_out), 32'h3);
    @(posedge sys_clk_in);
    mac_clk_running_in <= 2'h1;
    wr(PMC_OFFSET, 32'h00000040);
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in) chk(32'(mac_reset_out), 32'h2);
    mac_clk_running_in <= 2'h3;
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in) chk(32'(mac_reset_out), 32'h0);
    pulse(3);
    chk(32'({phy_reset_out, analog_ref_on_out}), 32'h2);
    wait_ready();
    chk(32'(n > 8), 32'h1);
    wr(PMC_OFFSET, 32'h00008040);
    pulse(3);
    chk(32'({phy_reset_out, analog_ref_on_out}), 32'h3);
    wait_ready();
    chk(32'(n <= 8), 32'h1);
    chk(rv, 32'h000080C0);
    complete_run();
  end
endmodule : tb_top

bind power_mgmt_control_reg power_mgmt_control_reg_sva i_power_mgmt_control_reg_sva (.*);
